/* dv/tid_tester.sv */
`timescale 1ns/100ps
// board tester model: owns the test clock, mode select, data in and test reset
module tid_tester (
  // pacing clock
  input  wire logic clk,
  // test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  input  wire logic tdo
);
  localparam int HALF = 8; // 80 ns high and 90 ns low keep both phases well above the sync delay

  // idle board: clock parked low, mode high so the port sits in reset
  initial begin
    tck    = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b1;
    trst_n = 1'b1;
  end

  // one test clock period; tdo is taken just before the rising edge
  task automatic cyc(input logic m, input logic d, output logic q);
    @(posedge clk);
    #1;
    tms = m;
    tdi = d;
    repeat (HALF) @(posedge clk);
    #1;
    q   = tdo;
    tck = 1'b1;
    repeat (HALF) @(posedge clk);
    #1;
    tck = 1'b0;
  endtask

  // stay in run-test/idle; tdi rests at its pull-up level
  task automatic idle(input int n);
    logic q;
    repeat (n) cyc(1'b0, 1'b1, q);
  endtask

  // idle -> scan of n bits (n = 0 only captures) -> update -> idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    cyc(1'b1, 1'b1, q);
    if (ir) cyc(1'b1, 1'b1, q);
    cyc(1'b0, 1'b1, q);
    if (n > 0) cyc(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], q);
      dout[i] = q;
    end
    if (n == 0) cyc(1'b1, 1'b1, q);
    cyc(1'b1, 1'b1, q);
    cyc(1'b0, 1'b1, q);
  endtask

  // five high mode-select cycles reach reset, then back to idle
  task automatic tlr();
    logic q;
    repeat (5) cyc(1'b1, 1'b1, q);
    cyc(1'b0, 1'b1, q);
  endtask

  // pulse the test reset pin long enough to pass its synchroniser
  task automatic trst_pulse();
    @(posedge clk);
    #1;
    trst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    trst_n = 1'b1;
    idle(1);
  endtask
endmodule

/* dv/tid_top_tb_top.sv */
`timescale 1ns/100ps
module tid_top_tb_top import tid_pkg::*;;
  localparam logic [10:0] ID_MAKER = 11'h155;  // arbitrary value
  localparam logic [15:0] ID_PART  = 16'h5a3c; // arbitrary value
  localparam logic [3:0]  ID_REV   = 4'h6;     // arbitrary value
  localparam logic [31:0] ID_VAL   = {ID_REV, ID_PART, ID_MAKER, ID_MARKER};
  localparam int          LIMIT    = 60000;
  logic              clk = 1'b0;
  logic              rst_n;
  logic              tck;
  logic              tms;
  logic              tdi;
  logic              trst_n;
  logic              tdo;
  logic              tdo_oe_n;
  logic [N_PINS-1:0] core_out;
  logic [N_PINS-1:0] core_oe;
  logic [N_PINS-1:0] pin_in;
  logic [N_PINS-1:0] pin_out;
  logic [N_PINS-1:0] pin_oe_n;
  logic [BSR_W-1:0]  snap_data;
  logic              snap_valid;
  logic              snap_ready = 1'b0;
  logic              snap_room;
  logic              hold = 1'b0;
  logic [5:0]        ir;
  logic [BSR_W-1:0]  latch;
  logic              ac_inv;
  logic [BSR_W-1:0]  q_snap[$];
  int                mismatches = 0;
  int                checked = 0;
  int                cycles = 0;
  int                rnd;
  // the serial line has no pull, so a released line shows the tester the inverse
  wire               tdo_line = tdo_oe_n ? ~tdo : tdo;

  tid_top #(.MAKER_CODE(ID_MAKER), .PART_CODE(ID_PART), .REV_CODE(ID_REV)) dut (
    .clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .snap_data(snap_data), .snap_valid(snap_valid), .snap_ready(snap_ready),
    .snap_room(snap_room));
  tid_tester tst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_line));

  always #5 clk = ~clk;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // expected pad drive from the current instruction and the update latch
  task automatic chk_pins();
    logic [N_PINS-1:0] eo;
    logic [N_PINS-1:0] en;
    repeat (8) @(posedge clk);
    eo = core_out;
    en = ~core_oe;
    if (ir inside {OP_EXTEST, OP_CLAMP, OP_AC_TRAIN, OP_AC_PULSE}) begin
      for (int i = 0; i < N_PINS; i++) begin
        eo[i] = latch[2*i];
        en[i] = ~latch[2*i+1];
      end
      if (ir inside {OP_AC_TRAIN, OP_AC_PULSE}) eo[1:0] = eo[1:0] ^ {2{ac_inv}};
    end
    if (ir == OP_HIGHZ) en = '1;
    chk_val("pin_out", 32'(eo), 32'(pin_out));
    chk_val("pin_oe_n", 32'(en), 32'(pin_oe_n));
  endtask

  // what the boundary cells hold after capture-DR
  function automatic logic [BSR_W-1:0] cap_vec();
    logic [BSR_W-1:0] v;
    for (int i = 0; i < N_PINS; i++) begin
      v[2*i]   = (ir == OP_EXTEST || !core_oe[i]) ? pin_in[i] : core_out[i];
      v[2*i+1] = core_oe[i];
    end
    return v;
  endfunction

  // only listed opcodes are ever loaded
  task automatic load_ir(input logic [5:0] op);
    logic [31:0] d;
    tst.scan(1'b1, IR_W, {26'h0, op}, d);
    chk_val("ir capture", 32'(CAPTURE_IR_PATTERN), d);
    ir     = op;
    ac_inv = 1'b1; // the closing idle edge starts the ac phase
  endtask

  task automatic dr(input int n, input logic [31:0] din);
    logic [31:0]      exp;
    logic [31:0]      m;
    logic [31:0]      d;
    logic [BSR_W-1:0] cap;
    logic             bnd;
    cap = cap_vec();
    bnd = ir inside {OP_EXTEST, OP_SAMPLE, OP_AC_TRAIN, OP_AC_PULSE};
    exp = '0;
    m   = '1;
    if (ir == OP_SAMPLE && snap_room === 1'b1) q_snap.push_back(cap);
    // ac capture content is left open, so only the pass-through part is judged
    if (ir inside {OP_AC_TRAIN, OP_AC_PULSE}) m[BSR_W-1:0] = '0;
    for (int i = 0; i < n; i++) begin
      if (ir == OP_IDCODE) exp[i] = ID_VAL[i];
      else if (bnd) exp[i] = (i < BSR_W) ? cap[i] : din[i-BSR_W];
      else exp[i] = (i == 0) ? BYPASS_CAPTURE : din[i-1];
    end
    tst.scan(1'b0, n, din, d);
    chk_val("dr scan", exp & m, d & m);
    chk_val("tdo_oe_n idle", 32'h1, 32'(tdo_oe_n));
    if (bnd && n >= BSR_W) latch = din[n-BSR_W +: BSR_W];
    ac_inv = 1'b1;
  endtask

  task automatic rand_pads();
    @(posedge clk);
    #1;
    core_out = N_PINS'($urandom);
    core_oe  = N_PINS'($urandom);
    pin_in   = N_PINS'($urandom);
    repeat (4) @(posedge clk);
  endtask

  // drain side: random stalls unless held, every accepted word compared
  always @(posedge clk) begin
    #1;
    snap_ready = hold ? 1'b0 : 1'($urandom);
  end
  always @(posedge clk) begin
    if (rst_n === 1'b1 && snap_valid === 1'b1 && snap_ready === 1'b1)
      chk_val("snapshot", q_snap.size() > 0 ? 32'(q_snap.pop_front()) : 'x, 32'(snap_data));
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    rnd = $urandom(32'h5ca2);
    rst_n = 1'b0;
    core_out = '0;
    core_oe = '0;
    pin_in = '0;
    ir = OP_IDCODE;
    ac_inv = 1'b0;
    latch = '0;
    repeat (12) @(posedge clk);
    chk_val("tdo_oe_n in reset", 32'h1, 32'(tdo_oe_n));
    chk_val("pin_oe_n in reset", 32'hff, 32'(pin_oe_n));
    #1;
    rst_n = 1'b1;
    rand_pads();
    chk_pins();
    tst.idle(1);
    dr(32, $urandom);
    load_ir(OP_SAMPLE);
    rand_pads();
    dr(BSR_W, $urandom);
    chk_pins();
    load_ir(OP_EXTEST);
    chk_pins();
    rand_pads();
    dr(BSR_W, $urandom);
    chk_pins();
    rand_pads();
    chk_pins();
    load_ir(OP_HIGHZ);
    chk_pins();
    dr(8, $urandom);
    load_ir(OP_CLAMP);
    chk_pins();
    dr(8, $urandom);
    load_ir(OP_BYPASS);
    dr(8, $urandom);
    chk_pins();
    tst.tlr();
    ir = OP_IDCODE;
    dr(32, $urandom);
    load_ir(OP_BYPASS);
    tst.trst_pulse();
    ir = OP_IDCODE;
    dr(32, $urandom);
    load_ir(OP_AC_TRAIN);
    chk_pins();
    tst.idle(1);
    ac_inv = ~ac_inv;
    chk_pins();
    dr(32, $urandom);
    chk_pins();
    load_ir(OP_AC_PULSE);
    chk_pins();
    tst.idle(3);
    chk_pins();
    // fill the snapshot buffer with the drain stalled, then drain it
    load_ir(OP_SAMPLE);
    for (int k = 0; k < 500 && q_snap.size() > 0; k++) @(posedge clk);
    hold = 1'b1;
    repeat (20) begin
      rand_pads();
      dr(0, 32'h0);
    end
    repeat (4) @(posedge clk);
    chk_val("snap_room when full", 32'h0, 32'(snap_room));
    chk_val("words kept", 32'h1, 32'(q_snap.size() >= FIFO_DEPTH));
    hold = 1'b0;
    for (int k = 0; k < 500 && q_snap.size() > 0; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk_val("snap_valid when empty", 32'h0, 32'(snap_valid));
    chk_val("snap_room when empty", 32'h1, 32'(snap_room));
    chk_val("words left", 32'h0, 32'(q_snap.size()));
    finish_test();
  end
endmodule

/* hdl/tid_pkg.sv */
package tid_pkg;
  // instruction codes
  localparam int       IR_W               = 6;
  localparam logic [5:0] OP_EXTEST        = 6'h00;
  localparam logic [5:0] OP_SAMPLE        = 6'h01;
  localparam logic [5:0] OP_IDCODE        = 6'h02;
  localparam logic [5:0] OP_HIGHZ         = 6'h03;
  localparam logic [5:0] CAPTURE_IR_PATTERN = 6'h2d;
  localparam logic [5:0] OP_AC_TRAIN      = 6'h3c;
  localparam logic [5:0] OP_AC_PULSE      = 6'h3d;
  localparam logic [5:0] OP_CLAMP         = 6'h3e;
  localparam logic [5:0] OP_BYPASS        = 6'h3f;
  // boundary chain: two cells per pin, data at 2i, enable at 2i+1
  localparam int       N_PINS             = 8;
  localparam int       N_AC               = 2;
  localparam int       BSR_W              = 2 * N_PINS;
  // identification layout
  localparam int       ID_W               = 32;
  localparam int       MAKER_LSB          = 1;
  localparam int       MAKER_W            = 11;
  localparam int       PART_LSB           = 12;
  localparam int       PART_W             = 16;
  localparam int       REV_LSB            = 28;
  localparam int       REV_W              = 4;
  localparam logic     ID_MARKER          = 1'b1;
  localparam logic     BYPASS_CAPTURE     = 1'b0;
  // test-logic reset is reached after this many high mode-select edges
  localparam int       TLR_TMS_CYCLES     = 5;
  // synchroniser and snapshot buffer
  localparam int       SYNC_W             = 4 + N_PINS;
  localparam int       FIFO_DEPTH         = 16;
  localparam int       FIFO_AW            = 4;
  // tap controller states
  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UPD_DR,
    S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
  } tid_tap_t;
endpackage

/* hdl/tid_top.sv */
`timescale 1ns/100ps
// snapshot buffer; output word sits in a register so the drain side sees flops
module tid_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   cnt;
  logic [AW:0]   next_cnt;
  wire           push = in_valid & in_ready;
  wire           load = (~out_valid | out_ready) & (cnt != '0);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  // count moves by push minus load
  assign next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  // storage writes only, no reset needed on the array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers, output stage and honest full flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      cnt       <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      cnt      <= next_cnt;
      in_ready <= next_cnt != FULL_CNT;
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load) begin
        out_data  <= mem[rd_ptr];
        rd_ptr    <= rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

module tid_top import tid_pkg::*; #(
  parameter logic [MAKER_W-1:0] MAKER_CODE = 11'h2a5,  // arbitrary value
  parameter logic [PART_W-1:0]  PART_CODE  = 16'h1234, // arbitrary value
  parameter logic [REV_W-1:0]   REV_CODE   = 4'h1      // arbitrary value
) (
  // system clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // test port pins
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  input  wire logic              trst_n,
  output logic                   tdo,
  output logic                   tdo_oe_n,
  // core side of the boundary pins
  input  wire logic [N_PINS-1:0] core_out,
  input  wire logic [N_PINS-1:0] core_oe,
  // pad side of the boundary pins
  input  wire logic [N_PINS-1:0] pin_in,
  output logic [N_PINS-1:0]      pin_out,
  output logic [N_PINS-1:0]      pin_oe_n,
  // sampled snapshot stream
  output logic [BSR_W-1:0]       snap_data,
  output logic                   snap_valid,
  input  wire logic              snap_ready,
  output logic                   snap_room
);
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic              tck_d;
  tid_tap_t          state;
  tid_tap_t          next_state;
  logic [IR_W-1:0]   ir_shift;
  logic [IR_W-1:0]   ir;
  logic [BSR_W-1:0]  bsr_shift;
  logic [BSR_W-1:0]  bsr_upd;
  logic [ID_W-1:0]   id_shift;
  logic              bypass_bit;
  logic              ac_phase;
  logic [BSR_W-1:0]  cap_vec;
  logic [N_PINS-1:0] next_pin_out;
  logic [N_PINS-1:0] next_pin_oe_n;
  logic [N_PINS-1:0] upd_data;

  // synchronised pins: tck, tms, tdi, trst_n, then pads
  wire               tck_s    = sync2[0];
  wire               tms_s    = sync2[1];
  wire               tdi_s    = sync2[2];
  wire               trst_s   = sync2[3];
  wire [N_PINS-1:0]  pin_in_s = sync2[SYNC_W-1:4];
  wire               tck_rise = tck_s & ~tck_d;
  wire               tck_fall = ~tck_s & tck_d;

  // instruction decode; reserved codes fall back to the bypass bit
  wire is_extest = ir == OP_EXTEST;
  wire is_sample = ir == OP_SAMPLE;
  wire is_train  = ir == OP_AC_TRAIN;
  wire is_pulse  = ir == OP_AC_PULSE;
  wire is_highz  = ir == OP_HIGHZ;
  wire sel_id    = ir == OP_IDCODE;
  wire sel_bsr   = is_extest | is_sample | is_train | is_pulse;
  wire sel_byp   = ~sel_id & ~sel_bsr;
  wire drive_bsr = is_extest | is_train | is_pulse | (ir == OP_CLAMP);
  wire ac_mode   = is_train | is_pulse;
  wire [ID_W-1:0] id_value = {REV_CODE, PART_CODE, MAKER_CODE, ID_MARKER};
  wire            dr_out   = sel_id ? id_shift[0] : sel_bsr ? bsr_shift[0] : bypass_bit;

  // two-flop synchroniser; tck edges are found on the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      tck_d <= 1'b0;
    end else begin
      sync1 <= {pin_in, trst_n, tdi, tms, tck};
      sync2 <= sync1;
      tck_d <= sync2[0];
    end
  end

  // tap transitions; five high tms edges always end in reset
  always_comb begin
    next_state = state;
    unique case (state)
      S_TLR:    next_state = tms_s ? S_TLR : S_RTI;
      S_RTI:    next_state = tms_s ? S_SEL_DR : S_RTI;
      S_SEL_DR: next_state = tms_s ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: next_state = tms_s ? S_EX1_DR : S_SH_DR;
      S_SH_DR:  next_state = tms_s ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: next_state = tms_s ? S_UPD_DR : S_PA_DR;
      S_PA_DR:  next_state = tms_s ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: next_state = tms_s ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: next_state = tms_s ? S_SEL_DR : S_RTI;
      S_SEL_IR: next_state = tms_s ? S_TLR : S_CAP_IR;
      S_CAP_IR: next_state = tms_s ? S_EX1_IR : S_SH_IR;
      S_SH_IR:  next_state = tms_s ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: next_state = tms_s ? S_UPD_IR : S_PA_IR;
      S_PA_IR:  next_state = tms_s ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: next_state = tms_s ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: next_state = tms_s ? S_SEL_DR : S_RTI;
    endcase
  end

  // tap state advances on rising tck; test reset pin forces reset state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_TLR;
    end else if (!trst_s) begin
      state <= S_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // instruction shifter: capture pattern, then shift lsb first on rising tck
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_shift <= CAPTURE_IR_PATTERN;
    end else if (tck_rise && state == S_CAP_IR) begin
      ir_shift <= CAPTURE_IR_PATTERN;
    end else if (tck_rise && state == S_SH_IR) begin
      ir_shift <= {tdi_s, ir_shift[IR_W-1:1]};
    end
  end

  // current instruction loads on falling tck in update-IR; test reset pin or reset state selects identification
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir <= OP_IDCODE;
    end else if (!trst_s || state == S_TLR) begin
      ir <= OP_IDCODE;
    end else if (tck_fall && state == S_UPD_IR) begin
      ir <= ir_shift;
    end
  end

  // capture vector per pin; bidirectional data cell follows the enable, except under extest where it always takes the pad
  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    wire from_pad = is_extest | ~core_oe[i];
    wire ac_inv   = (i < N_AC) & ac_mode & ac_phase;
    assign cap_vec[2*i]     = from_pad ? pin_in_s[i] : core_out[i];
    assign cap_vec[2*i+1]   = core_oe[i];
    assign upd_data[i]      = bsr_upd[2*i];
    assign next_pin_out[i]  = drive_bsr ? (bsr_upd[2*i] ^ ac_inv) : core_out[i];
    assign next_pin_oe_n[i] = is_highz ? 1'b1 : drive_bsr ? ~bsr_upd[2*i+1] : ~core_oe[i];
  end

  // data registers capture and shift on rising tck
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bsr_shift  <= '0;
      id_shift   <= '0;
      bypass_bit <= 1'b0;
    end else if (tck_rise && state == S_CAP_DR) begin
      if (sel_bsr) begin
        bsr_shift <= cap_vec;
      end
      if (sel_id) begin
        id_shift <= id_value;
      end
      bypass_bit <= BYPASS_CAPTURE;
    end else if (tck_rise && state == S_SH_DR) begin
      if (sel_bsr) begin
        bsr_shift <= {tdi_s, bsr_shift[BSR_W-1:1]};
      end
      if (sel_id) begin
        id_shift <= {tdi_s, id_shift[ID_W-1:1]};
      end
      bypass_bit <= tdi_s;
    end
  end

  // negative-edge update latch avoids skew between shift and update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bsr_upd <= '0;
    end else if (tck_fall && state == S_UPD_DR && sel_bsr) begin
      bsr_upd <= bsr_shift;
    end
  end

  // ac phase: training toggles, pulse stays high, only while idling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ac_phase <= 1'b0;
    end else if (tck_fall) begin
      ac_phase <= (state == S_RTI) ? (is_train ? ~ac_phase : 1'b1) : 1'b0;
    end
  end

  // serial output changes on falling tck, driven only while shifting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo      <= (state == S_SH_IR) ? ir_shift[0] : dr_out;
      tdo_oe_n <= ~(state == S_SH_IR || state == S_SH_DR);
    end
  end

  // pad drive registered so every pin leaves from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out  <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // sample captures are queued; a full buffer drops the snapshot, the scan still works
  tid_fifo #(
    .W     (BSR_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_snap (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (cap_vec),
    .in_valid  (tck_rise && state == S_CAP_DR && is_sample),
    .in_ready  (snap_room),
    .out_data  (snap_data),
    .out_valid (snap_valid),
    .out_ready (snap_ready)
  );

  // checks
  ir_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    !trst_s |=> ir == OP_IDCODE) else $error("reset did not select identification");
  cap_ir_a: assert property (@(posedge clk) disable iff (!rst_n)
    tck_rise && state == S_CAP_IR |=> ir_shift == CAPTURE_IR_PATTERN) else $error("capture-IR pattern wrong");
  byp_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    tck_rise && state == S_CAP_DR |=> !bypass_bit) else $error("bypass bit not cleared");
  highz_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_highz |=> pin_oe_n == '1) else $error("pins driven under high-z");
  extest_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_extest |=> pin_out == $past(upd_data)) else $error("extest pin value wrong");
  ir_update_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(ir) |-> $past(tck_fall && state == S_UPD_IR) || $past(!trst_s || state == S_TLR))
    else $error("instruction changed outside update-IR");
  id_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    tck_rise && state == S_CAP_DR && sel_id |=> id_shift[0] && id_shift[PART_LSB +: PART_W] == PART_CODE)
    else $error("identification value wrong");
  upd_dr_a: assert property (@(posedge clk) disable iff (!rst_n)
    tck_fall && state == S_UPD_DR && sel_bsr |=> bsr_upd == $past(bsr_shift))
    else $error("update-DR lost data");
  clamp_path_a: assert property (@(posedge clk) disable iff (!rst_n)
    ir == OP_CLAMP && tck_fall && state == S_SH_DR |=> tdo == $past(bypass_bit))
    else $error("clamp not through bypass");
  pulse_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    tck_fall && state != S_RTI |=> !ac_phase) else $error("ac pulse outside idle");
endmodule
